// *** hdl/ppw_port.sv ***
// What this block does
// - Strobe stays active for field value plus one ticks, one to sixteen.
// - Write hold after strobe lasts field value plus one ticks.
// - Read hold after strobe lasts field value ticks, zero to three.
// - Strobe field zero forces setup one, hold one write, zero read.
// - Top two bits used as selects are never stepped.
// - Auto stepping changes the location by one, any width.
// - Upper eight data lines driven only in wide transfer mode.
// - Location bits 15 and 14 are select bits or location bits.
// - Select function field decides role of the two top pins.
// - Location register holds 16 bits, all writable, reset to zero.
// - Low output buffer register, 16 bits.
// - High output buffer register, 16 bits.
// - Low input/output buffer carries host read and write data.
// - High input/output buffer register, 16 bits.
// - Claim bits 15:14 hand top pins to the port.
// - Claim bits 13:2 hand location pins to the port.
// - Claim bits 1:0 hand pins 1 and 0 to the port.
// - Multiplex mode picks location bits or latch strobes on pins 1:0.
// - Select field: 00 none, 01 second only, 10 both, 11 reserved.
// - Step field: 00 none, 01 up, 10 down, 11 none.
// - Multiplex field: 00 separate lines, any other value latch strobes on pins 1:0; data lines never carry the location.
// - Setup field gives one to four ticks before the strobe.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ppw_consts.svh"

module ppw_port
    import ppw_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [15:0] reg_rdata,
    input  wire logic [15:0] data_pins_in,
    output var  logic [15:0] data_pins_out,
    output var  logic [15:0] data_pins_oe,
    output var  logic [15:0] location_pins,
    output var  logic [15:0] location_pins_claimed,
    output var  logic        second_select_line,
    output var  logic        first_select_line,
    output var  logic        latch_strobe_high,
    output var  logic        latch_strobe_low,
    output var  logic        rd_strobe,
    output var  logic        wr_strobe
);

    logic [15:0] ctrl_q;
    logic [15:0] mode_q;
    logic [15:0] loc_q;
    logic [15:0] outlo_q;
    logic [15:0] outhi_q;
    logic [15:0] iolo_q;
    logic [15:0] iohi_q;
    logic [15:0] claim_q;
    ppw_state_t  state_q;
    logic [3:0]  cnt_q;
    logic        is_rd_q;
    logic [15:0] din_s1_q;
    logic [15:0] din_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // Decoded fields
    logic [1:0] select_function_field;
    logic [1:0] mux;
    logic [1:0] inc;
    logic [1:0] set_f;
    logic [3:0] stb_f;
    logic [1:0] hld_f;
    logic       wide;
    logic       busy;
    logic       go_wr;
    logic       go_rd;
    logic [3:0] setup_ticks;
    logic [3:0] hold_ticks;
    logic [15:0] loc_step;
    logic [15:0] step_mask;

    assign select_function_field   = ctrl_q[`PPW_C_CSF_HI:`PPW_C_CSF_LO];
    assign mux   = ctrl_q[`PPW_C_MUX_HI:`PPW_C_MUX_LO];
    assign inc   = mode_q[`PPW_M_INC_HI:`PPW_M_INC_LO];
    assign set_f = mode_q[`PPW_M_SET_HI:`PPW_M_SET_LO];
    assign stb_f = mode_q[`PPW_M_STB_HI:`PPW_M_STB_LO];
    assign hld_f = mode_q[`PPW_M_HLD_HI:`PPW_M_HLD_LO];
    assign wide  = mode_q[`PPW_M_WIDE];
    assign busy  = (state_q != PPW_IDLE);
    // A new cycle is only taken while idle; requests during a cycle drop
    assign go_wr = reg_wr && reg_addr == `PPW_A_GO
                   && reg_wdata[`PPW_G_WR] && !busy;
    assign go_rd = reg_wr && reg_addr == `PPW_A_GO
                   && reg_wdata[`PPW_G_RD] && !reg_wdata[`PPW_G_WR] && !busy;

    // Setup and hold, with the minimum-strobe override
    always_comb begin
        if (stb_f == `PPW_STB_MIN) begin
            setup_ticks = `PPW_CNT_ONE;
            hold_ticks  = is_rd_q ? `PPW_CNT_ZERO : `PPW_CNT_ONE;
        end else begin
            setup_ticks = {2'b00, set_f} + `PPW_CNT_ONE;
            if (is_rd_q) begin
                hold_ticks = {2'b00, hld_f};
            end else begin
                hold_ticks = {2'b00, hld_f} + `PPW_CNT_ONE;
            end
        end
    end

    // Select bits are kept out of the carry path so they never step
    always_comb begin
        if (select_function_field == `PPW_CSF_BOTH) begin
            step_mask = `PPW_LOC_MASK;
        end else if (select_function_field == `PPW_CSF_ONE) begin
            step_mask = `PPW_LOC_MASK | 16'h4000;
        end else begin
            step_mask = 16'hffff;
        end
        if (inc == `PPW_INC_UP) begin
            loc_step = ((loc_q + `PPW_ONE16) & step_mask)
                       | (loc_q & ~step_mask);
        end else if (inc == `PPW_INC_DN) begin
            loc_step = ((loc_q - `PPW_ONE16) & step_mask)
                       | (loc_q & ~step_mask);
        end else begin
            loc_step = loc_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser, two stages before any use
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            din_s1_q <= `PPW_ZERO16;
            din_s2_q <= `PPW_ZERO16;
        end else begin
            din_s1_q <= data_pins_in;
            din_s2_q <= din_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencer: setup, strobe, hold
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_q <= PPW_IDLE;
            cnt_q   <= `PPW_CNT_ZERO;
            is_rd_q <= 1'b0;
        end else begin
            case (state_q)
                PPW_IDLE: begin
                    if (go_wr || go_rd) begin
                        state_q <= PPW_SETUP;
                        is_rd_q <= go_rd;
                        cnt_q   <= `PPW_CNT_ZERO;
                    end
                end
                PPW_SETUP: begin
                    if (cnt_q == setup_ticks - `PPW_CNT_ONE) begin
                        state_q <= PPW_STB;
                        cnt_q   <= `PPW_CNT_ZERO;
                    end else begin
                        cnt_q <= cnt_q + `PPW_CNT_ONE;
                    end
                end
                PPW_STB: begin
                    if (cnt_q == stb_f) begin
                        cnt_q <= `PPW_CNT_ZERO;
                        if (hold_ticks == `PPW_CNT_ZERO) begin
                            state_q <= PPW_IDLE;
                        end else begin
                            state_q <= PPW_HOLD;
                        end
                    end else begin
                        cnt_q <= cnt_q + `PPW_CNT_ONE;
                    end
                end
                PPW_HOLD: begin
                    if (cnt_q == hold_ticks - `PPW_CNT_ONE) begin
                        state_q <= PPW_IDLE;
                        cnt_q   <= `PPW_CNT_ZERO;
                    end else begin
                        cnt_q <= cnt_q + `PPW_CNT_ONE;
                    end
                end
                default: begin
                    state_q <= PPW_IDLE;
                    cnt_q   <= `PPW_CNT_ZERO;
                end
            endcase
        end
    end

    // Cycle end point: last strobe tick or last hold tick
    logic cyc_done;
    assign cyc_done = (state_q == PPW_HOLD
                       && cnt_q == hold_ticks - `PPW_CNT_ONE)
                      || (state_q == PPW_STB && cnt_q == stb_f
                          && hold_ticks == `PPW_CNT_ZERO);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_q  <= `PPW_ZERO16;
            mode_q  <= `PPW_ZERO16;
            outlo_q <= `PPW_ZERO16;
            outhi_q <= `PPW_ZERO16;
            iohi_q  <= `PPW_ZERO16;
            claim_q <= `PPW_ZERO16;
        end else if (reg_wr) begin
            if (reg_addr == `PPW_A_CTRL) begin
                ctrl_q <= reg_wdata;
            end else if (reg_addr == `PPW_A_MODE) begin
                mode_q <= reg_wdata & 16'h7fff; // Busy bit is status
            end else if (reg_addr == `PPW_A_OUTLO) begin
                outlo_q <= reg_wdata;
            end else if (reg_addr == `PPW_A_OUTHI) begin
                outhi_q <= reg_wdata;
            end else if (reg_addr == `PPW_A_IOHI) begin
                iohi_q <= reg_wdata;
            end else if (reg_addr == `PPW_A_CLAIM) begin
                claim_q <= reg_wdata;
            end
        end
    end

    // Location register: hardware step at cycle end beats a software write
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            loc_q <= `PPW_ZERO16;
        end else if (cyc_done) begin
            loc_q <= loc_step;
        end else if (reg_wr && reg_addr == `PPW_A_LOC) begin
            loc_q <= reg_wdata;
        end
    end

    // Host data word: written by software, captured at read strobe end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            iolo_q <= `PPW_ZERO16;
        end else if (state_q == PPW_STB && cnt_q == stb_f && is_rd_q) begin
            iolo_q <= wide ? din_s2_q : {8'h00, din_s2_q[7:0]};
        end else if (reg_wr && reg_addr == `PPW_A_IOLO) begin
            iolo_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata <= `PPW_ZERO16;
        end else if (reg_rd) begin
            if (reg_addr == `PPW_A_CTRL) begin
                reg_rdata <= ctrl_q;
            end else if (reg_addr == `PPW_A_MODE) begin
                reg_rdata <= {busy, mode_q[14:0]};
            end else if (reg_addr == `PPW_A_LOC) begin
                reg_rdata <= loc_q;
            end else if (reg_addr == `PPW_A_OUTLO) begin
                reg_rdata <= outlo_q;
            end else if (reg_addr == `PPW_A_OUTHI) begin
                reg_rdata <= outhi_q;
            end else if (reg_addr == `PPW_A_IOLO) begin
                reg_rdata <= iolo_q;
            end else if (reg_addr == `PPW_A_IOHI) begin
                reg_rdata <= iohi_q;
            end else if (reg_addr == `PPW_A_CLAIM) begin
                reg_rdata <= claim_q;
            end else begin
                reg_rdata <= `PPW_ZERO16; // Unmapped reads as zero
            end
        end else begin
            reg_rdata <= `PPW_ZERO16;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin roles, registered so outputs come from flip-flops
    logic sel2_role;
    logic sel1_role;
    logic latch_role;
    assign sel2_role  = (select_function_field == `PPW_CSF_ONE) || (select_function_field == `PPW_CSF_BOTH);
    assign sel1_role  = (select_function_field == `PPW_CSF_BOTH);
    assign latch_role = (mux != `PPW_MUX_SEP);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            location_pins         <= `PPW_ZERO16;
            location_pins_claimed <= `PPW_ZERO16;
            second_select_line    <= 1'b0;
            first_select_line     <= 1'b0;
            latch_strobe_high     <= 1'b0;
            latch_strobe_low      <= 1'b0;
        end else begin
            location_pins_claimed <= claim_q;
            location_pins[13:2] <= loc_q[13:2] & claim_q[13:2];
            location_pins[15] <= !sel2_role && claim_q[15] && loc_q[15];
            location_pins[14] <= !sel1_role && claim_q[14] && loc_q[14];
            second_select_line <= sel2_role && claim_q[15]
                                  && loc_q[15] && busy;
            first_select_line  <= sel1_role && claim_q[14]
                                  && loc_q[14] && busy;
            location_pins[1:0] <= latch_role ? 2'b00
                                  : loc_q[1:0] & claim_q[1:0];
            latch_strobe_high <= latch_role && claim_q[1]
                                 && state_q == PPW_SETUP;
            latch_strobe_low  <= latch_role && claim_q[0]
                                 && state_q == PPW_SETUP;
        end
    end

    // Strobes and data bus drive
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_strobe     <= 1'b0;
            wr_strobe     <= 1'b0;
            data_pins_out <= `PPW_ZERO16;
            data_pins_oe  <= `PPW_ZERO16;
        end else begin
            rd_strobe <= (state_q == PPW_STB) && is_rd_q;
            wr_strobe <= (state_q == PPW_STB) && !is_rd_q;
            data_pins_out <= iolo_q;
            if (busy && !is_rd_q) begin
                data_pins_oe <= wide ? 16'hffff : 16'h00ff;
            end else begin
                data_pins_oe <= `PPW_ZERO16;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks; setup of any length must hand over to the strobe phase
    sequence s_setup_to_strobe;
        state_q == PPW_SETUP ##[1:4] state_q == PPW_STB;
    endsequence
    sequence s_setup_three;
        (state_q == PPW_SETUP) [*3] ##1 state_q == PPW_STB;
    endsequence
    a_strobe_min_len: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(state_q == PPW_STB) && stb_f == `PPW_STB_MIN
        |=> state_q != PPW_STB)
        else $error("strobe longer than one tick at minimum setting");
    a_read_no_hold: assert property (
        @(posedge core_clk) disable iff (!nrst)
        state_q == PPW_STB && is_rd_q && stb_f == `PPW_STB_MIN
        |=> state_q == PPW_IDLE)
        else $error("read hold not zero at minimum strobe");
    a_write_hold: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(state_q == PPW_HOLD) && !is_rd_q && hld_f == 2'h3
        && stb_f != `PPW_STB_MIN |-> (state_q == PPW_HOLD) [*4])
        else $error("write hold shorter than four ticks");
    a_read_hold: assert property (
        @(posedge core_clk) disable iff (!nrst)
        state_q == PPW_STB && is_rd_q && hld_f == 2'h0
        && stb_f != `PPW_STB_MIN && cnt_q == stb_f
        |=> state_q == PPW_IDLE)
        else $error("read hold not zero for zero field");
    a_select_frozen: assert property (
        @(posedge core_clk) disable iff (!nrst)
        cyc_done && select_function_field == `PPW_CSF_BOTH
        |=> loc_q[15:14] == $past(loc_q[15:14]))
        else $error("select bits were stepped");
    a_step_by_one: assert property (
        @(posedge core_clk) disable iff (!nrst)
        cyc_done && inc == `PPW_INC_UP && select_function_field == `PPW_CSF_NONE
        |=> loc_q == $past(loc_q) + `PPW_ONE16)
        else $error("location did not step by one");
    a_upper_lines: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !wide && $stable(wide) |=> data_pins_oe[15:8] == 8'h00)
        else $error("upper data lines driven in narrow mode");
    a_phase_order: assert property (
        @(posedge core_clk) disable iff (!nrst)
        state_q == PPW_IDLE && (go_wr || go_rd)
        |=> s_setup_to_strobe)
        else $error("cycle did not run setup then strobe");
    a_setup_len: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(state_q == PPW_SETUP) && set_f == 2'h2 && stb_f != 4'h0
        |-> s_setup_three)
        else $error("setup not three ticks");

endmodule

`default_nettype wire

// *** hdl/ppw_consts.svh ***
`ifndef PPW_CONSTS_SVH
`define PPW_CONSTS_SVH
// Register addresses on the plain port (word index)
`define PPW_A_CTRL      4'h0
`define PPW_A_MODE      4'h1
`define PPW_A_LOC       4'h2
`define PPW_A_OUTLO     4'h3
`define PPW_A_OUTHI     4'h4
`define PPW_A_IOLO      4'h5
`define PPW_A_IOHI      4'h6
`define PPW_A_CLAIM     4'h7
`define PPW_A_GO        4'h8
// Control register fields
`define PPW_C_MUX_HI    12
`define PPW_C_MUX_LO    11
`define PPW_C_CSF_HI    7
`define PPW_C_CSF_LO    6
// Mode register fields
`define PPW_M_BUSY      15
`define PPW_M_INC_HI    12
`define PPW_M_INC_LO    11
`define PPW_M_WIDE      10
`define PPW_M_SET_HI    7
`define PPW_M_SET_LO    6
`define PPW_M_STB_HI    5
`define PPW_M_STB_LO    2
`define PPW_M_HLD_HI    1
`define PPW_M_HLD_LO    0
// Go register: bit 0 starts a write, bit 1 starts a read
`define PPW_G_WR        0
`define PPW_G_RD        1
// Field encodings
`define PPW_STB_MIN     4'h0
`define PPW_CSF_NONE    2'h0
`define PPW_CSF_ONE     2'h1
`define PPW_CSF_BOTH    2'h2
`define PPW_INC_UP      2'h1
`define PPW_INC_DN      2'h2
`define PPW_MUX_SEP     2'h0
// Widths and reset value
`define PPW_ZERO16      16'h0000
`define PPW_LOC_MASK    16'h3fff
`define PPW_ONE16       16'h0001
`define PPW_CNT_ONE     4'h1
`define PPW_CNT_ZERO    4'h0
`endif

// *** hdl/ppw_pkg.sv ***
`default_nettype none
package ppw_pkg;
    typedef enum logic [3:0] {
        PPW_IDLE  = 4'b0001,
        PPW_SETUP = 4'b0010,
        PPW_STB   = 4'b0100,
        PPW_HOLD  = 4'b1000
    } ppw_state_t;
endpackage
`default_nettype wire

// *** test/ppw_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module ppw_mem_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] resp_word,
    input  wire logic [15:0] data_pins_out,
    input  wire logic [15:0] data_pins_oe,
    input  wire logic        rd_strobe,
    input  wire logic        wr_strobe,
    output var  logic [15:0] data_pins_in,
    output var  logic [15:0] last_wr
);
    logic [15:0] junk_q = 16'h5a3c;
    logic        rd_d_q = 1'h0;

    ////////////////////////////////////////////////////////////////////////
    // The bus is undriven outside a read, so the pins show a pattern that
    // changes each cycle; a capture at the wrong moment cannot pass
    always @(posedge core_clk) begin
        junk_q <= junk_q + 16'h1357;
        rd_d_q <= rd_strobe;
    end

    // Read data held through the strobe and one cycle of hold after it
    assign data_pins_in = (rd_strobe | rd_d_q) ? resp_word : junk_q;

    // Only lines the device drives are taken, as a real part would latch
    initial last_wr = 16'h0000;
    always @(posedge core_clk) begin
        if (wr_strobe) begin
            last_wr <= data_pins_out & data_pins_oe;
        end
    end
endmodule

`default_nettype wire

// *** test/tb_ppw_port.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ppw_consts.svh"

module tb_ppw_port
    import ppw_pkg::*;
;
    logic        core_clk, nrst, reg_wr, reg_rd, meas;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, data_pins_in, data_pins_out;
    logic [15:0] data_pins_oe, location_pins, location_pins_claimed;
    logic        second_select_line, first_select_line;
    logic        latch_strobe_high, latch_strobe_low, rd_strobe, wr_strobe;
    logic [15:0] resp_word, last_wr, oe_or, loc_or;
    logic [1:0]  sel_or, lat_or;
    int          n_stb, n_cs, es, eh, cyc, err_total, n_compared;
    logic        t_rd  [6] = '{0, 1, 0, 1, 1, 0};
    logic [1:0]  t_set [6] = '{0, 3, 3, 1, 2, 1};
    logic [3:0]  t_stb [6] = '{0, 0, 15, 1, 4, 2};
    logic [1:0]  t_hld [6] = '{3, 3, 3, 0, 3, 1};
    logic [15:0] lmask [4] = '{16'hffff, 16'h7fff, 16'h3fff, 16'hffff};
    logic [1:0]  s_exp [4] = '{0, 2, 3, 0};
    logic [1:0]  st_csf [5] = '{2, 1, 0, 0, 0};
    logic [1:0]  st_inc [5] = '{1, 2, 2, 0, 1};
    logic [15:0] st_loc [5] = '{16'hffff, 16'h8000, 16'h0000, 16'h1234,
                               16'h7fff};
    logic [15:0] st_exp [5] = '{16'hc000, 16'hffff, 16'hffff, 16'h1234,
                               16'h8000};

    ppw_port u_ppw_port (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .data_pins_in, .data_pins_out, .data_pins_oe,
        .location_pins, .location_pins_claimed, .second_select_line,
        .first_select_line, .latch_strobe_high, .latch_strobe_low,
        .rd_strobe, .wr_strobe);
    ppw_mem_model u_ppw_mem_model (.core_clk, .resp_word, .data_pins_out,
        .data_pins_oe, .rd_strobe, .wr_strobe, .data_pins_in, .last_wr);

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the ceiling is far above the roughly 1100
    // cycles the tests need
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial cyc = 0;
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            stop_test();
        end
    end

    // Pins sampled mid-cycle so the counts never race the design's edge
    always @(negedge core_clk) begin
        if (meas) begin
            n_stb = n_stb + int'(rd_strobe | wr_strobe);
            n_cs = n_cs + int'(first_select_line);
            oe_or = oe_or | data_pins_oe;
            loc_or = loc_or | location_pins;
            sel_or = sel_or | {second_select_line, first_select_line};
            lat_or = lat_or | {latch_strobe_high, latch_strobe_low};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // A gap cycle follows each strobe so no signal is set twice at one edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        @(posedge core_clk);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        chk(reg_rdata, exp);
        @(posedge core_clk);
    endtask

    function automatic logic [15:0] ctl(logic [1:0] mux, logic [1:0] select_function_field);
        return {3'h0, mux, 3'h0, select_function_field, 6'h00};
    endfunction

    function automatic logic [15:0] mval(logic [1:0] inc, logic w,
        logic [1:0] s, logic [3:0] m, logic [1:0] h);
        return {3'h0, inc, w, 2'h0, s, m, h};
    endfunction

    task automatic cfg(input logic [15:0] c, input logic [15:0] m,
        input logic [15:0] loc, input logic [15:0] claim);
        wr(`PPW_A_CTRL, c);
        wr(`PPW_A_MODE, m);
        wr(`PPW_A_LOC, loc);
        wr(`PPW_A_CLAIM, claim);
    endtask

    // One port cycle; a nonzero bexp also retries go and checks busy
    task automatic run(input logic [15:0] g, input logic [15:0] bexp);
        n_stb = 0;
        n_cs = 0;
        oe_or = 16'h0000;
        loc_or = 16'h0000;
        sel_or = 2'h0;
        lat_or = 2'h0;
        meas = 1'h1;
        wr(`PPW_A_GO, g);
        if (bexp !== 16'h0000) begin
            wr(`PPW_A_GO, g);
            rchk(`PPW_A_MODE, bexp);
        end
        repeat (40) @(posedge core_clk);
        meas = 1'h0;
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        err_total = 0;
        n_compared = 0;
        nrst = 1'h0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        meas = 1'h0;
        resp_word = 16'ha55a;
        repeat (12) @(posedge core_clk);
        nrst <= 1'h1;
        @(posedge core_clk);
        // Reset contents, the write-only go index and an unmapped index
        for (int a = 0; a < 10; a++) begin
            rchk(4'(a), 16'h0000);
        end
        for (int a = 2; a < 8; a++) begin
            wr(4'(a), 16'hc3a5 ^ 16'(a));
        end
        wr(4'h9, 16'hffff);
        for (int a = 2; a < 8; a++) begin
            rchk(4'(a), 16'hc3a5 ^ 16'(a));
        end
        rchk(4'h9, 16'h0000);
        $display("test registers done");
        // Phase lengths; a zero strobe field overrides setup and hold
        for (int i = 0; i < 6; i++) begin
            wr(`PPW_A_IOLO, 16'h1234);
            cfg(ctl(2'h0, 2'h2), mval(2'h0, i == 2, t_set[i], t_stb[i],
                t_hld[i]), 16'hc000, 16'hc000);
            run(t_rd[i] ? 16'h0002 : 16'h0001, 16'h0000);
            es = (t_stb[i] == 0) ? 1 : t_set[i] + 1;
            eh = (t_stb[i] == 0) ? 0 : t_hld[i];
            eh = eh + int'(!t_rd[i]) + es + t_stb[i] + 1;
            chk(16'(n_stb), 16'(t_stb[i]) + 16'h0001);
            chk(16'(n_cs), 16'(eh));
            chk(oe_or, t_rd[i] ? 16'h0 : {{8{i == 2}}, 8'hff});
            if (!t_rd[i]) begin
                chk(last_wr, i == 2 ? 16'h1234 : 16'h0034);
            end
        end
        $display("test timing done");
        // Role of the two top bits under every select function code
        for (int c = 0; c < 4; c++) begin
            cfg(ctl(2'h0, 2'(c)), mval(2'h0, 1'h0, 2'h0, 4'h1, 2'h0),
                16'hc123, 16'hffff);
            run(16'h0002, 16'h0000);
            chk({14'h0, sel_or}, {14'h0, s_exp[c]});
            chk(loc_or, 16'hc123 & lmask[c]);
        end
        // Unclaimed pins stay out of the port, selects included
        cfg(ctl(2'h0, 2'h2), mval(2'h0, 1'h0, 2'h0, 4'h1, 2'h0),
            16'hffff, 16'h0ff3);
        run(16'h0002, 16'h0000);
        chk(loc_or, 16'h0ff3);
        chk(location_pins_claimed, 16'h0ff3);
        chk({14'h0, sel_or, lat_or}, 16'h0000);
        cfg(ctl(2'h1, 2'h0), mval(2'h0, 1'h0, 2'h0, 4'h1, 2'h0),
            16'hffff, 16'h0003);
        run(16'h0002, 16'h0000);
        chk(loc_or, 16'h0000);
        chk({14'h0, lat_or}, 16'h0003);
        $display("test pins done");
        // Stepping by one at the wrap points, no step with the step field off, select bits left alone
        for (int i = 0; i < 5; i++) begin
            cfg(ctl(2'h0, st_csf[i]), mval(st_inc[i], i == 4, 2'h0, 4'h1,
                2'h0), st_loc[i], 16'hffff);
            run(i[0] ? 16'h0002 : 16'h0001, 16'h0000);
            rchk(`PPW_A_LOC, st_exp[i]);
        end
        $display("test stepping done");
        // Read capture, narrow transfers keep the low byte only
        for (int w = 0; w < 2; w++) begin
            cfg(ctl(2'h0, 2'h0), mval(2'h0, w[0], 2'h1, 4'hf, 2'h2),
                16'h0000, 16'hffff);
            run(16'h0002, 16'h0000);
            chk(oe_or, 16'h0000);
            rchk(`PPW_A_IOLO, w ? 16'ha55a : 16'h005a);
        end
        // A go during a long write is dropped and busy reads back set
        cfg(ctl(2'h0, 2'h2), mval(2'h0, 1'h0, 2'h3, 4'hf, 2'h3),
            16'hc000, 16'hc000);
        run(16'h0001, 16'h8000 | mval(2'h0, 1'h0, 2'h3, 4'hf, 2'h3));
        chk(16'(n_stb), 16'h0010);
        chk(16'(n_cs), 16'h0018);
        rchk(`PPW_A_MODE, mval(2'h0, 1'h0, 2'h3, 4'hf, 2'h3));
        $display("test busy done");
        stop_test();
    end
endmodule

`default_nettype wire
